// ===== include/sbp_pkg.sv
// Package for the discoverable-parameter byte table and its serial read path.
// Assumes one 20 MHz clock; the SPI pins are sampled as asynchronous inputs.
// How it works
// - Byte 30h bits 1:0 read 01b
// - Byte 30h bit 2 reads one
// - Byte 30h bit 3 reads zero
// - Byte 30h bit 4 reads zero
// - Byte 30h bits 7:5 read 111b
// - Bit 16 reports dual-output fast read
// - Bits 18:17 report three-byte addressing only
// - Bit 19 reports no double-rate clocking
// - Byte 32h upper modes zero, 33h FFh
// - Bytes 38h/39h return 00h and FFh
// - Bytes 3Ah/3Bh return 00h and FFh
// - Zero codes mean wait/mode bits unsupported
// - Header pointer 30h, length 09h doublewords
package sbp_pkg;
	localparam logic [7:0] SBP_CMD_READ_PARAMS = 8'h5A;
	localparam logic [7:0] SBP_TABLE_BASE      = 8'h30;
	localparam logic [7:0] SBP_TABLE_LAST      = 8'h3B;
	localparam logic [7:0] SBP_HDR_PTR_ADDR    = 8'h0C;
	localparam logic [7:0] SBP_HDR_LEN_ADDR    = 8'h0B;
	localparam logic [7:0] SBP_HDR_LEN_VAL     = 8'h09;
	localparam logic [7:0] SBP_UNMAPPED_VAL    = 8'hFF;
	localparam logic [7:0] SBP_ERASE4K_OPCODE  = 8'h20;
	localparam logic [31:0] SBP_DENSITY_BITS   = 32'h003F_FFFF;
	localparam logic [1:0] SBP_ERASE_4K_CODE   = 2'h1;
	localparam logic [1:0] SBP_ADDR_3B_ONLY    = 2'h0;
	localparam logic [2:0] SBP_NO_MODE_BITS    = 3'h0;
	localparam logic [4:0] SBP_NO_WAIT_STATES  = 5'h00;
	localparam logic [7:0] SBP_NO_OPCODE       = 8'hFF;
	localparam int SBP_HDR_BYTES = 4; // opcode + 3 address bytes

	typedef struct packed {
		logic [7:0] data;
		logic [7:0] addr;
	} sbp_beat_t;

	typedef enum logic [3:0] {
		SBP_IDLE = 4'b0001,
		SBP_HDR  = 4'b0010,
		SBP_DUMMY = 4'b0100,
		SBP_DATA = 4'b1000
	} sbp_state_t;
endpackage

// ===== design/sbp_rom.sv
// Basic parameter table ROM with a serial read front end.
// Assumes SPI mode 0 pins sampled well below MCLK/4; one clock domain only.
// SCLK high and low phases must each last at least three MCLK periods.
// Deselect flushes the frame, the buffer and the output pins.
`timescale 1ns/10ps
`default_nettype none
module sbp_rom
	import sbp_pkg::*;
#(
	parameter int BUF_DEPTH = 2
) (
	// Clock and reset
	input  wire logic MCLK_IN,
	input  wire logic SRST_IN,
	// SPI pins
	input  wire logic CS_N_IN,
	input  wire logic SCLK_IN,
	input  wire logic SI_IN,
	output logic      SO_OUT,
	output logic      SO_OE_OUT
);

	////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rom_byte(input logic [7:0] a);
		logic [7:0] b;
		b = SBP_UNMAPPED_VAL;
		// Header bytes other than length and pointer read as unmapped
		case (a)
			SBP_HDR_LEN_ADDR: b = SBP_HDR_LEN_VAL;
			SBP_HDR_PTR_ADDR: b = SBP_TABLE_BASE;
			8'h30: b = {3'h7,
				1'b0,
				1'b0,
				1'b1,
				SBP_ERASE_4K_CODE};
			8'h31: b = SBP_ERASE4K_OPCODE;
			8'h32: b = {1'b1, 3'h0,
				1'b0,
				SBP_ADDR_3B_ONLY,
				1'b1};
			8'h33: b = 8'hFF;
			8'h34: b = SBP_DENSITY_BITS[7:0];
			8'h35: b = SBP_DENSITY_BITS[15:8];
			8'h36: b = SBP_DENSITY_BITS[23:16];
			8'h37: b = SBP_DENSITY_BITS[31:24];
			8'h38, 8'h3A: b = {SBP_NO_MODE_BITS, SBP_NO_WAIT_STATES};
			8'h39, 8'h3B: b = SBP_NO_OPCODE;
			default: b = SBP_UNMAPPED_VAL;
		endcase
		return b;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [1:0] cs_s_r;
	logic [1:0] sck_s_r;
	logic [1:0] si_s_r;
	logic       sck_d_r;
	// Chip select; two stages before anything reads it
	always_ff @(posedge MCLK_IN) begin
		cs_s_r <= {cs_s_r[0], CS_N_IN};
	end

	// Clock and data share one latency, so data lines up with its edge
	always_ff @(posedge MCLK_IN) begin
		sck_s_r <= {sck_s_r[0], SCLK_IN};
		si_s_r  <= {si_s_r[0], SI_IN};
	end

	// Edge detector taps the second stage only
	always_ff @(posedge MCLK_IN) begin
		sck_d_r <= sck_s_r[1];
	end
	wire logic cs_act = ~cs_s_r[1];
	wire logic sck_rise = sck_s_r[1] & ~sck_d_r;
	wire logic sck_fall = ~sck_s_r[1] & sck_d_r;

	////////////////////////////////////////////////////////////////////
	// Command and address capture
	sbp_state_t state_r;
	sbp_state_t state_nxt;
	logic [7:0] shin_r;
	logic [2:0] bit_r;
	logic [2:0] hdr_cnt_r;
	logic [7:0] addr_r;
	wire logic byte_done = sck_rise & (bit_r == 3'h7);
	wire logic [7:0] in_byte = {shin_r[6:0], si_s_r[1]};
	logic       cmd_taken_r; // First byte of this frame already decoded
	wire logic  in_idle   = (state_r == SBP_IDLE);
	wire logic  in_hdr    = (state_r == SBP_HDR);
	wire logic  in_data   = (state_r == SBP_DATA);
	wire logic  cmd_match = (in_byte == SBP_CMD_READ_PARAMS);
	// Counter runs 0..2 over the three address bytes
	wire logic  hdr_last  = (hdr_cnt_r == 3'(SBP_HDR_BYTES - 2));

	////////////////////////////////////////////////////////////////////
	// Byte buffer between ROM fetch and shifter
	// Two entries let the fetch run ahead, so a late load never starves the pin
	sbp_beat_t buf_mem [BUF_DEPTH];
	logic [1:0] buf_cnt_r;
	logic       wr_ptr_r;
	logic       rd_ptr_r;
	wire logic  buf_in_ready = (buf_cnt_r != 2'(BUF_DEPTH));
	wire logic  buf_in_valid = in_data;
	wire logic  buf_out_valid = (buf_cnt_r != 2'h0);
	wire logic [7:0] fetch_byte = rom_byte(addr_r);

	// Output shifter
	logic       shift_empty_r;
	logic [7:0] shout_r;
	logic [2:0] obit_r;
	wire logic  load_shift = buf_out_valid & shift_empty_r;
	wire logic  push = buf_in_valid & buf_in_ready;
	wire logic  shift_step = sck_fall & ~shift_empty_r;
	wire logic  shift_last = (obit_r == 3'h7);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SBP_IDLE: begin
				// Later bytes of a refused frame are ignored until deselect
				if (byte_done && !cmd_taken_r && cmd_match)
					state_nxt = SBP_HDR;
			end
			SBP_HDR:   if (byte_done && hdr_last) state_nxt = SBP_DUMMY;
			SBP_DUMMY: if (byte_done) state_nxt = SBP_DATA;
			SBP_DATA:  state_nxt = SBP_DATA;
			default:   state_nxt = SBP_IDLE;
		endcase
		// Deselect overrides every transition
		if (!cs_act)
			state_nxt = SBP_IDLE;
	end

	always_ff @(posedge MCLK_IN) begin
		if (SRST_IN || !cs_act) begin
			state_r     <= SBP_IDLE;
			cmd_taken_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (byte_done && in_idle)
				cmd_taken_r <= 1'b1;
		end
	end

	// Input shifter; a partial byte at deselect is dropped
	always_ff @(posedge MCLK_IN) begin
		if (SRST_IN || !cs_act) begin
			bit_r  <= 3'h0;
			shin_r <= 8'h00;
		end else if (sck_rise) begin
			shin_r <= in_byte;
			bit_r  <= bit_r + 3'h1;
		end
	end

	// Address capture, then one step per fetched byte
	always_ff @(posedge MCLK_IN) begin
		if (SRST_IN || !cs_act) begin
			hdr_cnt_r <= 3'h0;
			addr_r    <= 8'h00;
		end else begin
			if (byte_done && in_hdr) begin
				hdr_cnt_r <= hdr_cnt_r + 3'h1;
				addr_r    <= in_byte; // Low address byte arrives last
			end
			if (push)
				addr_r <= addr_r + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Buffer and output shifter; flushed at chip deselect
	always_ff @(posedge MCLK_IN) begin
		if (push)
			buf_mem[wr_ptr_r] <= '{data: fetch_byte, addr: addr_r};
	end

	always_ff @(posedge MCLK_IN) begin
		if (SRST_IN || !cs_act) begin
			buf_cnt_r <= 2'h0;
			wr_ptr_r  <= 1'b0;
			rd_ptr_r  <= 1'b0;
		end else begin
			buf_cnt_r <= buf_cnt_r + 2'(push) - 2'(load_shift);
			if (push)
				wr_ptr_r <= ~wr_ptr_r;
			if (load_shift)
				rd_ptr_r <= ~rd_ptr_r;
		end
	end

	// Output shifter; the next byte loads while the pin still shows bit 0
	always_ff @(posedge MCLK_IN) begin
		if (SRST_IN || !cs_act) begin
			shift_empty_r <= 1'b1;
			shout_r       <= 8'h00;
			obit_r        <= 3'h0;
		end else if (load_shift) begin
			shout_r       <= buf_mem[rd_ptr_r].data;
			shift_empty_r <= 1'b0;
			obit_r        <= 3'h0;
		end else if (shift_step) begin
			shout_r <= {shout_r[6:0], 1'b0};
			obit_r  <= obit_r + 3'h1;
			if (shift_last)
				shift_empty_r <= 1'b1;
		end
	end

	// Bit shows about three clocks after the pin edge; this caps SCLK
	always_ff @(posedge MCLK_IN) begin
		if (SRST_IN || !cs_act) begin
			SO_OUT    <= 1'b0;
			SO_OE_OUT <= 1'b0;
		end else if (shift_step) begin
			SO_OUT    <= shout_r[7];
			SO_OE_OUT <= 1'b1;
		end
	end

endmodule // sbp_rom
`default_nettype wire

// ===== test/sbp_rom_props.sv
// Port checks for the parameter ROM.
// Bound into sbp_rom; single clock.
`timescale 1ns/10ps
`default_nettype none
module sbp_rom_props #(parameter int BUF_DEPTH = 2) (
	input wire logic MCLK_IN,
	input wire logic SRST_IN,
	input wire logic CS_N_IN,
	input wire logic SCLK_IN,
	input wire logic SI_IN,
	input wire logic SO_OUT,
	input wire logic SO_OE_OUT
);
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (SRST_IN);
	a_reset_oe: assert property (disable iff (1'b0) SRST_IN |=> !SO_OE_OUT)
		else $error("oe in reset");
	a_reset_so: assert property (disable iff (1'b0) SRST_IN |=> !SO_OUT)
		else $error("so in reset");
	a_cs_release: assert property ($rose(CS_N_IN) |-> ##[1:5] !SO_OE_OUT)
		else $error("oe kept");
	a_idle_quiet: assert property (CS_N_IN [*6] |-> !SO_OE_OUT)
		else $error("oe idle");
	a_bit_steady: assert property (SCLK_IN [*4] |-> $stable(SO_OUT))
		else $error("so moved");
	a_oe_steady: assert property (SCLK_IN [*4] |-> $stable(SO_OE_OUT))
		else $error("oe moved");
	a_oe_start: assert property ($rose(SO_OE_OUT) |-> !SCLK_IN && !$past(CS_N_IN, 8))
		else $error("oe early");
	a_oe_drop_cs: assert property ($fell(SO_OE_OUT) |-> CS_N_IN)
		else $error("oe dropped");
	c_drive: cover property ($rose(SO_OE_OUT));
	c_one: cover property (SO_OE_OUT && SO_OUT);
	c_end: cover property ($fell(SO_OE_OUT));
endmodule // sbp_rom_props
bind sbp_rom sbp_rom_props #(.BUF_DEPTH(BUF_DEPTH)) u_props (.MCLK_IN(MCLK_IN),
	.SRST_IN(SRST_IN), .CS_N_IN(CS_N_IN), .SCLK_IN(SCLK_IN), .SI_IN(SI_IN),
	.SO_OUT(SO_OUT), .SO_OE_OUT(SO_OE_OUT));
`default_nettype wire

// ===== test/sbp_host_model.sv
// Host reading the parameter space.
// Pins move at clk fall; SCLK half period 8 clocks.
`timescale 1ns/10ps
`default_nettype none
module sbp_host_model (
	input  wire logic clk,
	input  wire logic so,
	input  wire logic so_oe,
	output logic      cs_n,
	output logic      sclk,
	output logic      si
);
	logic [7:0] got[$];
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
	end
	task automatic rd(input logic [7:0] op, input logic [7:0] a, input int nb);
		logic [39:0] hdr;
		logic [7:0] v;
		hdr = {op, 16'h0000, a, 8'h00};
		got.delete();
		cs_n = 1'b0;
		for (int i = 0; i < nb; i++) begin
			si = (i < 40) ? hdr[39-i] : ~si; // Never a stale level
			repeat (8) @(negedge clk);
			// An undriven pin reads as the inverse, never as data
			v = {v[6:0], so_oe ? so : ~so};
			sclk = 1'b1;
			repeat (8) @(negedge clk);
			sclk = 1'b0;
			if (i >= 40 && i % 8 == 7) got.push_back(v);
		end
		cs_n = 1'b1;
		repeat (8) @(negedge clk);
	endtask
endmodule // sbp_host_model
`default_nettype wire

// ===== test/sbp_rom_test.sv
// Bench for the parameter ROM.
// Host model drives the pins.
`timescale 1ns/10ps
`default_nettype none
module sbp_rom_test;
	import sbp_pkg::*;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic oe_seen = 1'b0;
	wire logic cs_n, sclk, si, so, so_oe;
	int mismatches = 0;
	int n_tests = 0;
	int cyc = 0;
	initial begin
		forever #25 mclk = ~mclk;
	end
	sbp_rom u_dut (.MCLK_IN(mclk), .SRST_IN(srst), .CS_N_IN(cs_n), .SCLK_IN(sclk),
		.SI_IN(si), .SO_OUT(so), .SO_OE_OUT(so_oe));
	sbp_host_model u_host (.clk(mclk), .so(so), .so_oe(so_oe), .cs_n(cs_n),
		.sclk(sclk), .si(si));
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (so_oe === 1'b1) oe_seen = 1'b1;
		if (cyc == 20000) begin
			mismatches++;
			close_out();
		end
	end
	task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk(input logic [7:0] e[$]);
		cmp("count", 8'(e.size()), 8'(u_host.got.size()));
		foreach (e[i]) cmp($sformatf("byte %0d", i), e[i], u_host.got[i]);
	endtask
	task automatic t_table;
		u_host.rd(SBP_CMD_READ_PARAMS, 8'h30, 136);
		chk({8'hE5, 8'h20, 8'h81, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h00,
			8'h00, 8'hFF, 8'h00, 8'hFF});
	endtask
	task automatic t_refused;
		oe_seen = 1'b0;
		// Read opcode later in a refused frame must not start a read
		u_host.rd(8'h03, SBP_CMD_READ_PARAMS, 80);
		cmp("oe refused", 8'h00, {7'h00, oe_seen});
	endtask
	task automatic t_abort;
		oe_seen = 1'b0;
		u_host.rd(SBP_CMD_READ_PARAMS, 8'h30, 44);
		cmp("abort", 8'h02, {6'h00, oe_seen, so_oe});
	endtask
	task automatic t_header;
		u_host.rd(SBP_CMD_READ_PARAMS, 8'h0B, 56);
		chk({8'h09, 8'h30});
	endtask
	initial begin
		repeat (10) @(negedge mclk);
		srst = 1'b0;
		repeat (4) @(negedge mclk);
		t_table();
		t_refused();
		t_abort();
		t_header();
		close_out();
	end
endmodule // sbp_rom_test
`default_nettype wire
